// ### design/ues_pkg.sv
// constants, register map and field layout of the serial error status and interrupt block
// assumes a single 250 MHz clock and a plain strobe register port
package ues_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_MODE = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_ERR = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_RXBUF = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_ISTAT = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 3'h4;
  localparam int MODE_OPEN_BIT = 0;
  localparam int MODE_RECEIVE_ENABLE_BIT_BIT = 1;
  localparam int ERR_PE_BIT = 0;
  localparam int ERR_FE_BIT = 1;
  localparam int ERR_OV_BIT = 2;
  localparam int IRQ_TX_BIT = 0;
  localparam int IRQ_RX_BIT = 1;
  localparam int IRQ_ERR_BIT = 2;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [2:0] IMASK_RST = 3'h0;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [DATA_W-1:0] RXBUF_RST = 8'h00;
  localparam logic TX_HIST_RST = 1'b1;
endpackage : ues_pkg

// ### design/ues_err_if.sv
// signals between the receive controller and the error status holder
// assumes both ends share clk_i
`timescale 1ns/1ps
`default_nettype none
interface ues_err_if;
  logic set_pe;
  logic set_fe;
  logic set_ov;
  logic clr;
  logic [2:0] flags;
  modport ctl (output set_pe, output set_fe, output set_ov, output clr, input flags);
  modport stat (input set_pe, input set_fe, input set_ov, input clr, output flags);
endinterface : ues_err_if
`default_nettype wire

// ### design/ues_err_stat.sv
// receive error status holder: three sticky flags, set wins over clear
// assumes clr and sets come from the controller in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module ues_err_stat (
  input wire logic clk_i,
  input wire logic resetn_i,
  ues_err_if.stat e
);
  import ues_pkg::*;

  logic [2:0] sets;
  assign sets = {e.set_ov, e.set_fe, e.set_pe};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      e.flags <= FLAGS_RST;
    end else begin
      e.flags <= (e.flags & ~{3{e.clr}}) | sets;
    end
  end

  a_clear_drops_flags: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (e.clr && sets == 3'h0) |=> e.flags == 3'h0)
    else $error("flags survived a clear");
  a_set_beats_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (e.clr && e.set_ov) |=> e.flags[ERR_OV_BIT])
    else $error("overrun lost against a clear");
endmodule : ues_err_stat
`default_nettype wire

// ### design/ues_top.sv
// serial channel error status, receive buffer transfer and interrupt generation
// assumes the shifter reports frames as one-cycle strobes and tx emptiness as a level
`timescale 1ns/1ps
`default_nettype none
module ues_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ues_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ues_pkg::DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [ues_pkg::DATA_W-1:0] rdata_o,
  input wire logic frame_done_i,
  input wire logic [ues_pkg::DATA_W-1:0] rx_data_i,
  input wire logic parity_bad_i,
  input wire logic stop_bad_i,
  input wire logic tx_shift_empty_i,
  output logic channel_operation_enable_o,
  output logic rx_active_o,
  output logic transmit_done_interrupt_o,
  output logic receive_done_interrupt_o,
  output logic irq_o
);
  import ues_pkg::*;

  logic [1:0] mode_r;
  logic [2:0] imask_r;
  logic [2:0] istat_r;
  logic [DATA_W-1:0] rxbuf_r;
  logic rxbuf_full_r;
  logic tx_empty_q_r;
  logic tx_done_r;
  logic rx_done_r;
  logic rx_on;
  logic frame_ok;
  logic accept;
  logic overrun;
  logic rd_err;
  logic rd_rxbuf;
  logic rd_istat;
  logic tx_event;
  logic [2:0] irq_sets;
  logic [DATA_W-1:0] rdata_nxt;

  ues_err_if err_bus ();

  ues_err_stat u_err (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .e(err_bus.stat)
  );

  assign rx_on = mode_r[MODE_OPEN_BIT] & mode_r[MODE_RECEIVE_ENABLE_BIT_BIT];
  assign frame_ok = rx_on & frame_done_i;
  assign overrun = frame_ok & rxbuf_full_r;
  assign accept = frame_ok & ~rxbuf_full_r;
  assign rd_err = re_i && addr_i == OFF_ERR;
  assign rd_rxbuf = re_i && addr_i == OFF_RXBUF;
  assign rd_istat = re_i && addr_i == OFF_ISTAT;

  // error flag sources and clears
  assign err_bus.set_pe = accept & parity_bad_i;
  assign err_bus.set_fe = accept & stop_bad_i;
  assign err_bus.set_ov = overrun;
  assign err_bus.clr = rd_err | ~rx_on;

  // mode and mask registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= MODE_RST;
      imask_r <= IMASK_RST;
    end else if (we_i) begin
      if (addr_i == OFF_MODE) begin
        mode_r <= wdata_i[1:0];
      end
      if (addr_i == OFF_IMASK) begin
        imask_r <= wdata_i[2:0];
      end
    end
  end

  assign channel_operation_enable_o = mode_r[MODE_OPEN_BIT];
  assign rx_active_o = rx_on;

  // receive buffer: frozen while reception is off or on overrun
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxbuf_r <= RXBUF_RST;
    end else if (accept) begin
      rxbuf_r <= rx_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxbuf_full_r <= 1'b0;
    end else begin
      rxbuf_full_r <= accept | (rxbuf_full_r & ~rd_rxbuf);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= accept;
    end
  end

  assign receive_done_interrupt_o = rx_done_r;

  // transmit done: rising emptiness only while the channel runs
  assign tx_event = tx_shift_empty_i & ~tx_empty_q_r & mode_r[MODE_OPEN_BIT];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_empty_q_r <= TX_HIST_RST;
      tx_done_r <= 1'b0;
    end else begin
      tx_empty_q_r <= tx_shift_empty_i;
      tx_done_r <= tx_event;
    end
  end

  assign transmit_done_interrupt_o = tx_done_r;

  // sticky interrupt status, cleared by its read, set wins
  assign irq_sets = {(err_bus.set_pe | err_bus.set_fe | err_bus.set_ov), rx_done_r, tx_done_r};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      istat_r <= FLAGS_RST;
    end else begin
      istat_r <= (istat_r & ~{3{rd_istat}}) | irq_sets;
    end
  end

  assign irq_o = |(istat_r & imask_r);

  // read data, one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_nxt = '0;
    unique case (addr_i)
      OFF_MODE: rdata_nxt = {6'h00, mode_r};
      OFF_ERR: rdata_nxt = {5'h00, err_bus.flags};
      OFF_RXBUF: rdata_nxt = rxbuf_r;
      OFF_ISTAT: rdata_nxt = {5'h00, istat_r};
      OFF_IMASK: rdata_nxt = {5'h00, imask_r};
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= '0;
    end
  end

  a_disable_clears_err: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !rx_on |=> err_bus.flags == 3'h0)
    else $error("error flags kept while reception off");
  a_err_read_value: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_err |=> rdata_o == {5'h00, $past(err_bus.flags)})
    else $error("error read returned wrong value");
  a_tx_done_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (tx_shift_empty_i && !tx_empty_q_r && mode_r[MODE_OPEN_BIT]) |=> transmit_done_interrupt_o ##1
    !transmit_done_interrupt_o)
    else $error("transmit done not a single pulse");
  a_tx_reset_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !mode_r[MODE_OPEN_BIT] |=> !transmit_done_interrupt_o)
    else $error("transmit done raised while channel held in reset");
  a_rx_off_holds: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !rx_on |=> $stable(rxbuf_r) && !receive_done_interrupt_o)
    else $error("buffer changed while reception off");
  a_rx_transfer_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (frame_ok && !rxbuf_full_r) |=> receive_done_interrupt_o && rxbuf_r == $past(rx_data_i))
    else $error("frame transfer and receive done out of step");
  a_overrun_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (frame_ok && rxbuf_full_r) |=> err_bus.flags[ERR_OV_BIT] && $stable(rxbuf_r))
    else $error("overrun not flagged or buffer overwritten");

  // interrupt status, read port and flag source checks
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !re_i |=> rdata_o == '0)
    else $error("read data not zero outside a read");
  a_istat_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !rd_istat |=> (istat_r & $past(istat_r)) == $past(istat_r))
    else $error("interrupt status bit lost without a read");
  a_err_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !err_bus.clr |=> (err_bus.flags & $past(err_bus.flags)) == $past(err_bus.flags))
    else $error("error flag lost without a clear");
  a_parity_sets: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (accept && parity_bad_i) |=> err_bus.flags[ERR_PE_BIT])
    else $error("parity flag not set");
  a_stop_sets: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (accept && stop_bad_i) |=> err_bus.flags[ERR_FE_BIT])
    else $error("framing flag not set");
  a_rx_pulse_single: assert property (@(posedge clk_i) disable iff (!resetn_i)
    receive_done_interrupt_o |=> !receive_done_interrupt_o)
    else $error("receive done longer than one cycle");
  a_rx_istat: assert property (@(posedge clk_i) disable iff (!resetn_i)
    receive_done_interrupt_o |=> istat_r[IRQ_RX_BIT])
    else $error("receive done not recorded in status");
  a_tx_needs_edge: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(tx_shift_empty_i && !tx_empty_q_r) |=> !transmit_done_interrupt_o)
    else $error("transmit done without a finished transmission");
  a_tx_istat: assert property (@(posedge clk_i) disable iff (!resetn_i)
    transmit_done_interrupt_o |=> istat_r[IRQ_TX_BIT])
    else $error("transmit done not recorded in status");
  a_err_istat: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (err_bus.set_pe || err_bus.set_fe || err_bus.set_ov) |=> istat_r[IRQ_ERR_BIT])
    else $error("error event not recorded in status");

  c_rx_frame: cover property (@(posedge clk_i) disable iff (!resetn_i) frame_ok && !rxbuf_full_r);
  c_overrun: cover property (@(posedge clk_i) disable iff (!resetn_i) frame_ok && rxbuf_full_r);
  c_tx_done: cover property (@(posedge clk_i) disable iff (!resetn_i) transmit_done_interrupt_o);
  c_read_with_set: cover property (@(posedge clk_i) disable iff (!resetn_i) rd_err && err_bus.set_ov);
  c_rx_disable: cover property (@(posedge clk_i) disable iff (!resetn_i) rx_on ##1 !rx_on);
endmodule : ues_top
`default_nettype wire

// ### sim/ues_far_end.sv
// far-end model: shifter side, frame strobes and transmit emptiness
// assumes the bench asks for a frame one cycle before its strobe
`timescale 1ns/1ps
`default_nettype none
module ues_far_end (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic send_i,
  input wire logic [7:0] byte_i,
  input wire logic pbad_i,
  input wire logic sbad_i,
  input wire logic tx_busy_i,
  output logic frame_done_o,
  output logic [7:0] rx_data_o,
  output logic parity_bad_o,
  output logic stop_bad_o,
  output logic tx_shift_empty_o
);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_done_o <= 1'b0;
      rx_data_o <= 8'h00;
      parity_bad_o <= 1'b0;
      stop_bad_o <= 1'b0;
      tx_shift_empty_o <= 1'b1; // reset empties the shifter
    end else begin
      frame_done_o <= send_i;
      // outside a frame the lines toggle, never hold stale values
      rx_data_o <= send_i ? byte_i : ~rx_data_o;
      parity_bad_o <= send_i ? pbad_i : ~parity_bad_o;
      stop_bad_o <= send_i ? sbad_i : ~stop_bad_o;
      tx_shift_empty_o <= !tx_busy_i;
    end
  end
endmodule : ues_far_end
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench: register reads against a byte-level model
// assumes ues_top and the far-end model share one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ues_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic send = 1'b0;
  logic [7:0] sbyte = 8'h00;
  logic pbad = 1'b0;
  logic sbad = 1'b0;
  logic busy = 1'b0;
  logic fd, pb, sb, txe, coe, rxa, txi, rxi, irq;
  logic [7:0] rxd, rdata, m_mode, m_err, m_buf, m_ist, m_mask;
  logic m_full;
  int errors = 0;
  int n_checks = 0;
  int seed = 32'h0d7d;
  int r;
  always #2 clk_i = ~clk_i;
  ues_far_end i_ues_far_end (.clk_i(clk_i), .resetn_i(resetn_i), .send_i(send), .byte_i(sbyte),
    .pbad_i(pbad), .sbad_i(sbad), .tx_busy_i(busy), .frame_done_o(fd), .rx_data_o(rxd),
    .parity_bad_o(pb), .stop_bad_o(sb), .tx_shift_empty_o(txe));
  ues_top i_ues_top (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata), .we_i(we),
    .re_i(re), .rdata_o(rdata), .frame_done_i(fd), .rx_data_i(rxd), .parity_bad_i(pb), .stop_bad_i(sb),
    .tx_shift_empty_i(txe), .channel_operation_enable_o(coe), .rx_active_o(rxa),
    .transmit_done_interrupt_o(txi), .receive_done_interrupt_o(rxi), .irq_o(irq));
  task tally_and_finish;
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task do_reset;
    @(posedge clk_i);
    resetn_i <= 1'b0;
    busy <= 1'b0;
    {m_mode, m_err, m_buf, m_ist, m_mask, m_full} = '0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
  endtask : do_reset
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
    if (a == OFF_MODE) m_mode = {6'h00, d[1:0]};
    if (a == OFF_IMASK) m_mask = {5'h00, d[2:0]};
    if (m_mode[1:0] != 2'h3) m_err = 8'h00;
    #1;
    chk("enable", m_mode & 8'h01, {7'h00, coe});
    chk("rx_active", {7'h00, &m_mode[1:0]}, {7'h00, rxa});
  endtask : wr
  // whole-register reads only, never with the main clock stopped
  task rd(input logic [2:0] a);
    logic [7:0] e;
    e = (a == OFF_MODE) ? m_mode : (a == OFF_ERR) ? m_err : (a == OFF_RXBUF) ? m_buf :
        (a == OFF_ISTAT) ? m_ist : (a == OFF_IMASK) ? m_mask : 8'h00;
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1;
    chk("rdata", e, rdata);
    if (a == OFF_ERR) m_err = 8'h00;
    if (a == OFF_RXBUF) m_full = 1'b0;
    if (a == OFF_ISTAT) m_ist = 8'h00;
  endtask : rd
  task fr(input logic [7:0] b, input logic p, input logic s);
    logic ex;
    ex = 1'b0;
    @(posedge clk_i);
    send <= 1'b1;
    sbyte <= b;
    pbad <= p;
    sbad <= s;
    @(posedge clk_i);
    send <= 1'b0;
    if (m_mode[1:0] == 2'h3 && m_full) begin
      m_err[2] = 1'b1;
      m_ist[2] = 1'b1;
    end else if (m_mode[1:0] == 2'h3) begin
      ex = 1'b1;
      m_buf = b;
      m_full = 1'b1;
      m_err[1:0] = m_err[1:0] | {s, p};
      m_ist[1] = 1'b1;
      m_ist[2] = m_ist[2] | p | s;
    end
    @(posedge clk_i);
    #1;
    chk("rx_done", {7'h00, ex}, {7'h00, rxi});
  endtask : fr
  task tx;
    logic ex;
    ex = m_mode[0];
    @(posedge clk_i);
    busy <= 1'b1;
    repeat (3) @(posedge clk_i);
    busy <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("tx_done", {7'h00, ex}, {7'h00, txi});
    m_ist[0] = m_ist[0] | ex;
    @(posedge clk_i);
    #1;
    chk("irq", {7'h00, |(m_ist & m_mask)}, {7'h00, irq});
  endtask : tx
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    tally_and_finish;
  end
  initial begin
    do_reset;
    for (int a = 0; a < 8; a++) rd(a[2:0]);
    wr(OFF_MODE, 8'h03);
    wr(OFF_IMASK, 8'h07);
    fr(8'ha5, 1'b1, 1'b0);
    rd(OFF_ERR);
    rd(OFF_ERR);
    rd(OFF_RXBUF);
    fr(8'h3c, 1'b0, 1'b1);
    fr(8'hc3, 1'b0, 1'b0);
    rd(OFF_ERR);
    rd(OFF_RXBUF);
    rd(OFF_ISTAT);
    fr(8'h11, 1'b1, 1'b1);
    wr(OFF_MODE, 8'h01);
    rd(OFF_ERR);
    fr(8'h22, 1'b0, 1'b0);
    rd(OFF_RXBUF);
    wr(OFF_MODE, 8'h03);
    fr(8'h33, 1'b1, 1'b0);
    wr(OFF_MODE, 8'h02);
    rd(OFF_ERR);
    wr(OFF_MODE, 8'h03);
    repeat (40) begin
      r = $random(seed);
      if (r[0]) rd(OFF_RXBUF);
      else if (r[1]) rd(OFF_ERR);
      else fr(r[15:8], r[2] & !m_full, r[3] & !m_full);
    end
    rd(OFF_RXBUF);
    fr(8'h5a, 1'b1, 1'b0);
    // overrun frame lands on the same edge as an error read
    fork
      fr(8'ha6, 1'b0, 1'b0);
      begin
        @(posedge clk_i);
        rd(OFF_ERR);
      end
    join
    m_err[2] = 1'b1; // set wins over the read clear
    rd(OFF_ERR);
    rd(OFF_ISTAT);
    tx;
    rd(OFF_ISTAT);
    wr(OFF_MODE, 8'h00);
    tx;
    wr(OFF_MODE, 8'h01);
    @(posedge clk_i);
    busy <= 1'b1;
    repeat (3) @(posedge clk_i);
    do_reset;
    repeat (4) begin
      @(posedge clk_i);
      #1;
      chk("tx_done_reset", 8'h00, {7'h00, txi});
    end
    tally_and_finish;
  end
endmodule : testbench
`default_nettype wire
